/* File: core/rwc_reset_wake.sv */
// Summary of operation
// - waking dormant on battery with low core supply: hold processor, wake low
// - status 101 without sleep: reset processor four slow ticks later, then wait
// - waiting state ends when system power returns or core supply recovers
// - low-battery flag set on recovery, kept until wake falls, independent
// - reset pin high stops logic and clears every configuration bit
// - test selector reset by pin reset only when test pin also high
// - software reset bit acts as pin reset with a fixed 16-tick timer
// - with system power, reset timer runs 4100 slow ticks then releases
// - without system power, timer runs two ticks, start in brownout mode
// - debug reset low resets processor only, no configuration, no timer
// - watchdog overflow flag set on overflow, cleared only by pin reset
// - only debug enable pin high disables the watchdog
// - watchdog restarted by software bit, by wake, and while debug enabled
// - wake on pushbutton, serial edges, pin four rise, pin levels, optical edges
// - hardware wake raises wake and starts processor within three slow ticks
// - debounced pins act on first transition, ignore others in interval
// - undebounced wake pins must stay high 2 us before recognised
// - source flag set on wake; pushbutton flag set on every press
// - serial receive uses enable bit 4, flag bit 4, either edge, 2 us
// - arm bit loads wake timer; timer counts only while dormant
//
// The strobed register port was decided locally.
module rwc_reset_wake
	import rwc_pkg::*;
#(
	parameter int BOOT_TICKS_P  = BOOT_TICKS,
	parameter int SWRST_TICKS_P = SWRST_TICKS
) (
	input  wire logic              core_clk,
	input  wire logic              nrst,
	input  wire rwc_pkg::rwc_addr_t addr,
	input  wire rwc_pkg::rwc_data_t wrData,
	input  wire logic              wrEn,
	input  wire logic              rdEn,
	output rwc_pkg::rwc_data_t     rdData,
	input  wire logic              resetPin,
	input  wire logic              testPin,
	input  wire logic              debugResetN,
	input  wire logic              debugEnablePin,
	input  wire logic              systemPowerOk,
	input  wire logic [2:0]        powerStatusField,
	input  wire logic              crystalClock32k,
	input  wire logic              pushbuttonPin,
	input  wire logic              serialRxPin,
	input  wire logic              lcdPinFour,
	input  wire logic              lcdPinFiftyTwo,
	input  wire logic              lcdPinFiftyFive,
	input  wire logic              opticalReceivePin,
	input  wire logic              watchdogOverflow,
	input  wire logic              wakeTimerExpired,
	output logic                   cpuResetN,
	output logic                   wakeSignal,
	output logic                   brownoutMode,
	output logic                   configClear,
	output logic                   testSelectReset,
	output logic                   watchdogRestart,
	output logic                   watchdogDisable,
	output logic                   wakeTimerLoad,
	output logic                   wakeTimerRun
);
	import rwc_pkg::*;

	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic              xtalPrev_r;
	logic              tick;
	logic [SRC_N-1:0]  srcS;
	logic              rstPinS;
	logic              testS;
	logic              dbgRstNS;
	logic              dbgEnS;
	logic              sysPwrS;
	logic              lowVdd;
	logic              tstRst;
	logic [SRC_N-1:0]  evt;
	logic [4:0]        wakeHit;
	logic              tmrHit;
	logic              anyWake;
	logic              swRst;
	logic              noRst;
	logic              cfgClr;
	logic              wakeNxt;
	logic              wakeFell;
	logic              wdRstWr;
	rwc_state_e        state_r;
	logic [TCNT_W-1:0] tcnt_r;
	logic [7:5]        sleepCtl_r;
	logic [4:0]        wakeEn_r;
	logic              optDis_r;
	logic [7:0]        causeFlags_r;
	logic [5:0]        wakeFlags_r;
	rwc_data_t         rdMux;

	function automatic logic busHit(
		input logic      strobe,
		input rwc_addr_t a,
		input rwc_addr_t off
	);
		return strobe && (a == off);
	endfunction : busHit

	// pins and the crystal clock come from outside, two flops each
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			// debug reset idles high; a low reset value would log a false debug reset
			sync1_r <= {{(SYNC_W-9){1'b0}}, 1'b1, 8'h00};
			sync2_r <= {{(SYNC_W-9){1'b0}}, 1'b1, 8'h00};
		end else begin
			sync1_r <= {powerStatusField, crystalClock32k, systemPowerOk, debugEnablePin,
				debugResetN, testPin, resetPin, opticalReceivePin, serialRxPin,
				pushbuttonPin, lcdPinFour, lcdPinFiftyTwo, lcdPinFiftyFive};
			sync2_r <= sync1_r;
		end
	end

	assign srcS     = sync2_r[5:0];
	assign rstPinS  = sync2_r[6];
	assign testS    = sync2_r[7];
	assign dbgRstNS = sync2_r[8];
	assign dbgEnS   = sync2_r[9];
	assign sysPwrS  = sync2_r[10];
	assign lowVdd   = sync2_r[14:12] == VSTAT_LOW;
	assign tstRst   = rstPinS && testS;

	// slow clock becomes a one-cycle enable on its rising edge
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			xtalPrev_r <= 1'b0;
		end else begin
			xtalPrev_r <= sync2_r[11];
		end
	end
	assign tick = sync2_r[11] && !xtalPrev_r;

	for (genvar i = 0; i < SRC_N; i++) begin : g_src
		logic             q_r;
		logic             sq_r;
		logic             e_r;
		logic [CNT_W-1:0] c_r;

		always_ff @(posedge core_clk) begin
			if (!nrst) begin
				q_r <= 1'b0;
				c_r <= '0;
			end else if (DEB_MASK[i]) begin
				if (c_r != '0) begin
					if (tick) begin
						c_r <= c_r - 1'b1;
					end
				end else if (srcS[i] != q_r) begin
					q_r <= srcS[i];
					c_r <= DEB_LOAD;
				end
			end else if (srcS[i] == q_r) begin
				c_r <= '0;
			end else if (c_r == MIN_HIGH_LAST) begin
				q_r <= srcS[i];
				c_r <= '0;
			end else begin
				c_r <= c_r + 1'b1;
			end
		end

		// detection works on slow-clock samples, as the dormant part has no fast clock
		always_ff @(posedge core_clk) begin
			if (!nrst) begin
				sq_r <= 1'b0;
				e_r  <= 1'b0;
			end else if (tick) begin
				sq_r <= q_r;
				if (BOTH_MASK[i]) begin
					e_r <= q_r ^ sq_r;
				end else if (RISE_MASK[i]) begin
					e_r <= q_r && !sq_r;
				end else begin
					e_r <= q_r;
				end
			end else begin
				e_r <= 1'b0;
			end
		end
		assign evt[i] = e_r;
	end

	// optical receive shares flag and enable with lcd pin 55
	assign wakeHit = wakeEn_r & {evt[SRC_RX:1], optDis_r ? evt[0] : evt[SRC_OPT]};
	assign tmrHit  = sleepCtl_r[B_ARM] && wakeTimerExpired;
	assign anyWake = (|wakeHit) || tmrHit;

	assign swRst   = busHit(wrEn, addr, OFF_CLKCTL) && wrData[B_SWRST];
	assign wdRstWr = busHit(wrEn, addr, OFF_WDCTL) && wrData[B_WDRST];
	assign noRst   = !rstPinS && !swRst && !watchdogOverflow;
	assign cfgClr  = rstPinS || swRst;
	assign wakeNxt = (state_r == ST_RUN) || (state_r == ST_LOWPEND);
	assign wakeFell = wakeSignal && !wakeNxt;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_r <= ST_RSTTIMER;
			tcnt_r  <= TCNT_W'(BOOT_TICKS_P);
		end else if (rstPinS) begin
			state_r <= ST_RSTHOLD;
		end else if (swRst || watchdogOverflow) begin
			state_r <= ST_RSTTIMER;
			tcnt_r  <= swRst ? TCNT_W'(SWRST_TICKS_P) :
				(sysPwrS ? TCNT_W'(BOOT_TICKS_P) : NOPWR_LOAD);
		end else begin
			unique case (state_r)
				ST_RSTHOLD: begin
					state_r <= ST_RSTTIMER;
					tcnt_r  <= sysPwrS ? TCNT_W'(BOOT_TICKS_P) : NOPWR_LOAD;
				end
				ST_RSTTIMER: begin
					if (tick) begin
						if (tcnt_r <= TCNT_ONE) begin
							state_r <= ST_RUN;
						end else begin
							tcnt_r <= tcnt_r - 1'b1;
						end
					end
				end
				ST_RUN: begin
					if (sleepCtl_r[B_SLEEP] || sleepCtl_r[B_LCDONLY]) begin
						state_r <= ST_SLEEP;
					end else if (!sysPwrS && lowVdd) begin
						state_r <= ST_LOWPEND;
						tcnt_r  <= LOWBAT_LOAD;
					end
				end
				ST_LOWPEND: begin
					if (sleepCtl_r[B_SLEEP]) begin
						state_r <= ST_SLEEP;
					end else if (sysPwrS || !lowVdd) begin
						state_r <= ST_RUN;
					end else if (tick) begin
						if (tcnt_r <= TCNT_ONE) begin
							state_r <= ST_LOWWAIT;
						end else begin
							tcnt_r <= tcnt_r - 1'b1;
						end
					end
				end
				ST_LOWWAIT: begin
					if (sysPwrS || !lowVdd) begin
						state_r <= ST_RUN;
					end
				end
				ST_SLEEP: begin
					if (sysPwrS || anyWake) begin
						// a dormant wake first checks whether the core can run at all
						state_r <= (!sysPwrS && lowVdd) ? ST_LOWWAIT : ST_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wakeSignal      <= 1'b0;
			cpuResetN       <= 1'b0;
			brownoutMode    <= 1'b0;
			configClear     <= 1'b1;
			testSelectReset <= 1'b1;
		end else begin
			wakeSignal      <= wakeNxt;
			cpuResetN       <= wakeNxt && dbgRstNS;
			brownoutMode    <= !sysPwrS && (state_r != ST_SLEEP);
			configClear     <= cfgClr;
			testSelectReset <= tstRst;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			watchdogRestart <= 1'b0;
			watchdogDisable <= 1'b0;
		end else begin
			watchdogRestart <= wdRstWr || dbgEnS || (!wakeSignal && wakeNxt);
			watchdogDisable <= dbgEnS;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst || cfgClr) begin
			sleepCtl_r <= '0;
			wakeEn_r   <= '0;
			optDis_r   <= 1'b0;
		end else begin
			if (busHit(wrEn, addr, OFF_SLPCTL)) begin
				sleepCtl_r <= wrData[B_SLEEP:B_ARM];
			end else if (state_r == ST_SLEEP) begin
				// spent on entry, so a wake cannot fall straight back to sleep
				sleepCtl_r[B_SLEEP]   <= 1'b0;
				sleepCtl_r[B_LCDONLY] <= 1'b0;
			end
			if (busHit(wrEn, addr, OFF_WEN)) begin
				wakeEn_r <= wrData[SRC_RX:0];
			end
			if (busHit(wrEn, addr, OFF_OPTCTL)) begin
				optDis_r <= wrData[B_OPTDIS];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wakeTimerLoad <= 1'b0;
			wakeTimerRun  <= 1'b0;
		end else begin
			wakeTimerLoad <= busHit(wrEn, addr, OFF_SLPCTL) && wrData[B_ARM];
			wakeTimerRun  <= sleepCtl_r[B_ARM] && (state_r == ST_SLEEP);
		end
	end

	// set beats clear in every flag below
	always_ff @(posedge core_clk) begin
		if (!nrst || cfgClr) begin
			wakeFlags_r <= '0;
		end else begin
			for (int k = 0; k < 5; k++) begin
				if (wakeHit[k] && (state_r == ST_SLEEP || k == SRC_PB)) begin
					wakeFlags_r[k] <= 1'b1;
				end else if (wakeFell || !wakeEn_r[k]) begin
					wakeFlags_r[k] <= 1'b0;
				end
			end
			if (tmrHit && state_r == ST_SLEEP) begin
				wakeFlags_r[W_TMR] <= 1'b1;
			end else if (wakeFell) begin
				wakeFlags_r[W_TMR] <= 1'b0;
			end
		end
	end

	// cause flags live on the backed supply: configuration clears leave them alone
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			causeFlags_r           <= '0;
			causeFlags_r[C_CSTART] <= 1'b1;
		end else begin
			for (int k = C_ERST; k <= C_CSTART; k++) begin
				// a reset's own wake fall must not wipe the cause it just logged
				if (k != C_OVF && wakeFell && state_r != ST_RSTTIMER
						&& state_r != ST_RSTHOLD) begin
					causeFlags_r[k] <= 1'b0;
				end
			end
			if (rstPinS) begin
				causeFlags_r[C_RST] <= 1'b1;
			end
			if (swRst) begin
				causeFlags_r[C_RSTBIT] <= 1'b1;
			end
			if (!dbgRstNS) begin
				causeFlags_r[C_ERST] <= 1'b1;
			end
			if (watchdogOverflow) begin
				causeFlags_r[C_OVF] <= 1'b1;
			end else if (rstPinS) begin
				causeFlags_r[C_OVF] <= 1'b0;
			end
			if (state_r == ST_LOWWAIT && noRst && (sysPwrS || !lowVdd)) begin
				causeFlags_r[C_BADVDD] <= 1'b1;
			end else if (wakeFell) begin
				causeFlags_r[C_BADVDD] <= 1'b0;
			end
		end
	end

	always_comb begin
		unique case (addr)
			OFF_CAUSE:  rdMux = causeFlags_r;
			OFF_WFLAG:  rdMux = {2'h0, wakeFlags_r};
			OFF_SLPCTL: rdMux = {sleepCtl_r, 5'h00};
			OFF_WEN:    rdMux = {3'h0, wakeEn_r};
			OFF_OPTCTL: rdMux = {5'h00, optDis_r, 2'h0};
			default:    rdMux = '0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rdData <= '0;
		end else begin
			rdData <= rdEn ? rdMux : '0;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	sequence s_lowRecover;
		(state_r == ST_LOWWAIT) ##1 (state_r == ST_RUN);
	endsequence

	lowHold_a: assert property (
		(state_r == ST_LOWWAIT) |=> (!cpuResetN && !wakeSignal))
		else $error("processor not held while waiting on low supply");
	lowPend_a: assert property (
		(state_r == ST_LOWPEND) && tick && (tcnt_r == TCNT_ONE) && noRst && !sysPwrS
			&& lowVdd && !sleepCtl_r[B_SLEEP] |=> (state_r == ST_LOWWAIT))
		else $error("low supply reset not taken after countdown");
	lowWake_a: assert property (
		(state_r == ST_LOWWAIT) && noRst && (sysPwrS || !lowVdd)
			|=> (state_r == ST_RUN) ##1 wakeSignal)
		else $error("no wake after supply recovery");
	badFlag_a: assert property (
		s_lowRecover |-> causeFlags_r[C_BADVDD])
		else $error("low battery flag missing after recovery");
	pinCfg_a: assert property (
		rstPinS |=> (sleepCtl_r == '0) && (wakeEn_r == '0) && (wakeFlags_r == '0) && configClear)
		else $error("configuration survived pin reset");
	testSel_a: assert property (
		rstPinS && !testS |=> !testSelectReset)
		else $error("test selector reset without test pin");
	bootLoad_a: assert property (
		(state_r == ST_RSTHOLD) && noRst && sysPwrS |=> (tcnt_r == TCNT_W'(BOOT_TICKS_P)))
		else $error("boot timer not loaded with full count");
	noPwr_a: assert property (
		(state_r == ST_RSTHOLD) && noRst && !sysPwrS |=> (tcnt_r == NOPWR_LOAD))
		else $error("short timer not used without system power");
	dbgRst_a: assert property (
		!dbgRstNS && !rstPinS && !swRst |=> !cpuResetN && !configClear)
		else $error("debug reset wrong scope");
	ovfHold_a: assert property (
		causeFlags_r[C_OVF] && !rstPinS |=> causeFlags_r[C_OVF])
		else $error("overflow flag lost without pin reset");
	wdDebug_a: assert property (
		dbgEnS |=> watchdogDisable && watchdogRestart)
		else $error("watchdog not held off by debug enable");
	wakeFast_a: assert property (
		(state_r == ST_SLEEP) && anyWake && noRst && !lowVdd |-> ##2 (wakeSignal && cpuResetN
			|| !dbgRstNS))
		else $error("wake too slow");
	pbFlag_a: assert property (
		wakeHit[SRC_PB] && !cfgClr |=> wakeFlags_r[SRC_PB])
		else $error("pushbutton flag not set");
endmodule : rwc_reset_wake

/* File: core/rwc_pkg.sv */
package rwc_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	typedef logic [ADDR_W-1:0] rwc_addr_t;
	typedef logic [DATA_W-1:0] rwc_data_t;

	localparam rwc_addr_t OFF_CAUSE  = 16'h28b0;
	localparam rwc_addr_t OFF_WFLAG  = 16'h28b1;
	localparam rwc_addr_t OFF_SLPCTL = 16'h28b2;
	localparam rwc_addr_t OFF_WEN    = 16'h28b3;
	localparam rwc_addr_t OFF_WDCTL  = 16'h28b4;
	localparam rwc_addr_t OFF_CLKCTL = 16'h2200;
	localparam rwc_addr_t OFF_OPTCTL = 16'h2457;

	localparam int B_SLEEP   = 7;
	localparam int B_LCDONLY = 6;
	localparam int B_ARM     = 5;
	localparam int B_WDRST   = 7;
	localparam int B_SWRST   = 3;
	localparam int B_OPTDIS  = 2;
	localparam int C_CSTART  = 7;
	localparam int C_RST     = 6;
	localparam int C_RSTBIT  = 5;
	localparam int C_OVF     = 4;
	localparam int C_ERST    = 3;
	localparam int C_BADVDD  = 2;
	localparam int W_TMR     = 5;
	localparam int SRC_PB    = 3;
	localparam int SRC_RX    = 4;
	localparam int SRC_OPT   = 5;

	localparam logic [2:0] VSTAT_LOW = 3'h5;

	localparam int CLK_MHZ      = 40;
	localparam int MIN_HIGH_NS  = 2000;
	localparam int MIN_HIGH_CYC = (MIN_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int SLOW_HZ      = 32768;
	localparam int DEB_MS       = 64;
	localparam int DEB_TICKS    = DEB_MS * SLOW_HZ / 1000;
	localparam int LOWBAT_TICKS = 4;
	localparam int NOPWR_TICKS  = 2;
	localparam int BOOT_TICKS   = 4100;
	localparam int SWRST_TICKS  = 16;

	localparam int CNT_W  = 12;
	localparam int TCNT_W = 13;
	localparam logic [CNT_W-1:0]  MIN_HIGH_LAST = CNT_W'(MIN_HIGH_CYC - 1);
	localparam logic [CNT_W-1:0]  DEB_LOAD      = CNT_W'(DEB_TICKS);
	localparam logic [TCNT_W-1:0] LOWBAT_LOAD   = TCNT_W'(LOWBAT_TICKS);
	localparam logic [TCNT_W-1:0] NOPWR_LOAD    = TCNT_W'(NOPWR_TICKS);
	localparam logic [TCNT_W-1:0] TCNT_ONE      = 13'h0001;

	localparam int SRC_N = 6;
	localparam int SYNC_W = 15;
	localparam logic [SRC_N-1:0] DEB_MASK  = 6'h0b;
	localparam logic [SRC_N-1:0] RISE_MASK = 6'h04;
	localparam logic [SRC_N-1:0] BOTH_MASK = 6'h30;

	typedef enum logic [2:0] {
		ST_RSTHOLD  = 3'h6,
		ST_RSTTIMER = 3'h4,
		ST_RUN      = 3'h0,
		ST_SLEEP    = 3'h2,
		ST_LOWPEND  = 3'h1,
		ST_LOWWAIT  = 3'h3
	} rwc_state_e;
endpackage : rwc_pkg

/* File: tb/rwc_far_model.sv */
module rwc_far_model
	import rwc_pkg::*;
#(
	parameter int TICK_HALF = 8
) (
	input  wire logic        core_clk,
	input  wire logic        cpuResetN,
	output logic             crystalClock32k,
	output logic [SRC_N-1:0] pinLvl,
	output int               bootCount
);
	timeunit 1ns;
	timeprecision 1ps;
	int   divCnt;
	logic resetSeen;

	initial begin
		crystalClock32k = 1'b0;
		pinLvl = '0;
		divCnt = 0;
		bootCount = 0;
		resetSeen = 1'b0;
	end

	// crystal runs free, shortened so the run stays short
	always @(posedge core_clk) begin
		divCnt <= (divCnt == TICK_HALF - 1) ? 0 : divCnt + 1;
		if (divCnt == TICK_HALF - 1)
			crystalClock32k <= ~crystalClock32k;
	end

	// processor fetches from zero each time its reset lifts
	always @(posedge core_clk) begin
		resetSeen <= cpuResetN;
		if (cpuResetN && !resetSeen)
			bootCount <= bootCount + 1;
	end

	task automatic drivePin(input int idx, input logic lvl);
		@(posedge core_clk);
		pinLvl[idx] <= lvl;
	endtask : drivePin
endmodule : rwc_far_model

/* File: tb/test_reset_and_wake_controller.sv */
`define CHK(nm, ex, got) begin numChecks++; if ((got) !== (ex)) begin failures++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end
module test_reset_and_wake_controller;
	timeunit 1ns;
	timeprecision 1ps;
	import rwc_pkg::*;
	localparam int TICK = 16;
	localparam int S_WK = 0, S_RST = 1, S_WDR = 2, S_LD = 3, S_RUN = 4;
	logic       core_clk, nrst, wrEn, rdEn, resetPin, testPin, debugResetN, debugEnablePin;
	logic       systemPowerOk, watchdogOverflow, wakeTimerExpired, crystalClock32k;
	logic       cpuResetN, wakeSignal, brownoutMode, configClear, testSelectReset;
	logic       watchdogRestart, watchdogDisable, wakeTimerLoad, wakeTimerRun;
	logic [2:0] powerStatusField;
	logic [SRC_N-1:0] pinLvl;
	rwc_addr_t  addr;
	rwc_data_t  wrData, rdData;
	int         bootCount, failures, numChecks, n;

	rwc_reset_wake #(.BOOT_TICKS_P(8), .SWRST_TICKS_P(2)) u_rwc_reset_wake (
		.core_clk(core_clk), .nrst(nrst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
		.rdEn(rdEn), .rdData(rdData), .resetPin(resetPin), .testPin(testPin),
		.debugResetN(debugResetN), .debugEnablePin(debugEnablePin),
		.systemPowerOk(systemPowerOk), .powerStatusField(powerStatusField),
		.crystalClock32k(crystalClock32k), .pushbuttonPin(pinLvl[SRC_PB]),
		.serialRxPin(pinLvl[SRC_RX]), .lcdPinFour(pinLvl[2]), .lcdPinFiftyTwo(pinLvl[1]),
		.lcdPinFiftyFive(pinLvl[0]), .opticalReceivePin(pinLvl[SRC_OPT]),
		.watchdogOverflow(watchdogOverflow), .wakeTimerExpired(wakeTimerExpired),
		.cpuResetN(cpuResetN), .wakeSignal(wakeSignal), .brownoutMode(brownoutMode),
		.configClear(configClear), .testSelectReset(testSelectReset),
		.watchdogRestart(watchdogRestart), .watchdogDisable(watchdogDisable),
		.wakeTimerLoad(wakeTimerLoad), .wakeTimerRun(wakeTimerRun));

	rwc_far_model #(.TICK_HALF(TICK / 2)) u_rwc_far_model (
		.core_clk(core_clk), .cpuResetN(cpuResetN), .crystalClock32k(crystalClock32k),
		.pinLvl(pinLvl), .bootCount(bootCount));

	always #12.5 core_clk = ~core_clk;

	function automatic logic sig(input int sel);
		case (sel)
			S_WK: return wakeSignal;
			S_RST: return cpuResetN;
			S_WDR: return watchdogRestart;
			S_LD: return wakeTimerLoad;
			default: return wakeTimerRun;
		endcase
	endfunction : sig

	// polls just after each edge; n equals lim when the level never came
	task automatic waitSig(input int sel, input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while (cnt < lim && sig(sel) !== lvl) begin
			@(posedge core_clk);
			#1;
			cnt++;
		end
	endtask : waitSig

	task automatic wr(input rwc_addr_t a, input rwc_data_t d);
		@(posedge core_clk);
		addr <= a;
		wrData <= d;
		wrEn <= 1'b1;
		@(posedge core_clk);
		wrEn <= 1'b0;
		#1;
	endtask : wr

	task automatic chkReg(input rwc_addr_t a, input rwc_data_t m, input rwc_data_t ex,
			input string nm);
		rwc_data_t d;
		@(posedge core_clk);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge core_clk);
		rdEn <= 1'b0;
		#1;
		d = rdData;
		`CHK(nm, ex, d & m)
	endtask : chkReg

	task automatic pinReset(input logic tst);
		@(posedge core_clk);
		resetPin <= 1'b1;
		testPin <= tst;
		repeat (100) @(posedge core_clk);
		#1;
		`CHK("configClear", 1'b1, configClear)
		`CHK("cpuResetN held", 1'b0, cpuResetN)
		`CHK("testSelectReset", tst, testSelectReset)
		@(posedge core_clk);
		resetPin <= 1'b0;
		testPin <= 1'b0;
		#1;
	endtask : pinReset

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	initial begin
		core_clk = 1'b0;
		{nrst, wrEn, rdEn, resetPin, testPin, debugEnablePin} = '0;
		{watchdogOverflow, wakeTimerExpired, addr, wrData} = '0;
		{systemPowerOk, debugResetN, powerStatusField} = {2'b11, 3'h0};
		failures = 0;
		numChecks = 0;
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		#1;
		`CHK("cpuResetN after power-on", 1'b0, cpuResetN)
		chkReg(OFF_CAUSE, 8'h80, 8'h80, "cold cause");
		chkReg(OFF_SLPCTL, 8'hff, 8'h00, "sleep ctl reset");
		chkReg(OFF_WEN, 8'hff, 8'h00, "enables reset");
		chkReg(16'h1234, 8'hff, 8'h00, "unmapped");
		waitSig(S_RST, 1, 400, n);
		`CHK("boot time", 1'b1, n >= 6 * TICK && n < 400)
		`CHK("brownout with power", 1'b0, brownoutMode)
		wr(OFF_WEN, 8'h1f);
		`CHK("boot count", 1, bootCount)
		chkReg(OFF_WEN, 8'hff, 8'h1f, "enables rw");
		wr(OFF_WFLAG, 8'hff);
		chkReg(OFF_WFLAG, 8'hff, 8'h00, "flags read-only");
		$display("test reset_and_registers finished");
		@(posedge core_clk);
		watchdogOverflow <= 1'b1;
		@(posedge core_clk);
		watchdogOverflow <= 1'b0;
		waitSig(S_RST, 0, 20, n);
		waitSig(S_RST, 1, 400, n);
		chkReg(OFF_CAUSE, 8'h10, 8'h10, "overflow flag");
		@(posedge core_clk);
		debugResetN <= 1'b0;
		repeat (10) @(posedge core_clk);
		#1;
		`CHK("debug reset", 1'b0, cpuResetN)
		@(posedge core_clk);
		debugResetN <= 1'b1;
		waitSig(S_RST, 1, 20, n);
		`CHK("debug reset no timer", 1'b1, n < 20)
		chkReg(OFF_WEN, 8'hff, 8'h1f, "config kept");
		@(posedge core_clk);
		debugEnablePin <= 1'b1;
		repeat (6) @(posedge core_clk);
		#1;
		`CHK("wd disabled", 1'b1, watchdogDisable)
		`CHK("wd restart held", 1'b1, watchdogRestart)
		@(posedge core_clk);
		debugEnablePin <= 1'b0;
		repeat (6) @(posedge core_clk);
		#1;
		`CHK("wd enabled", 1'b0, watchdogDisable)
		wr(OFF_WDCTL, 8'h80);
		waitSig(S_WDR, 1, 5, n);
		`CHK("wd restart bit", 1'b1, n < 5)
		$display("test watchdog_debug finished");
		pinReset(1'b0);
		waitSig(S_RST, 1, 400, n);
		`CHK("pin boot time", 1'b1, n >= 6 * TICK && n < 400)
		chkReg(OFF_WEN, 8'hff, 8'h00, "pin clears config");
		chkReg(OFF_CAUSE, 8'h50, 8'h40, "pin cause");
		pinReset(1'b1);
		waitSig(S_RST, 1, 400, n);
		wr(OFF_WEN, 8'h08);
		wr(OFF_CLKCTL, 8'h08);
		waitSig(S_RST, 0, 10, n);
		`CHK("sw reset taken", 1'b1, n < 10)
		waitSig(S_RST, 1, 400, n);
		`CHK("sw reset short", 1'b1, n < 4 * TICK)
		chkReg(OFF_WEN, 8'hff, 8'h00, "sw clears config");
		chkReg(OFF_CAUSE, 8'h20, 8'h20, "sw cause");
		$display("test resets finished");
		@(posedge core_clk);
		systemPowerOk <= 1'b0;
		pinReset(1'b0);
		waitSig(S_RST, 1, 400, n);
		`CHK("battery boot short", 1'b1, n < 4 * TICK)
		`CHK("brownout start", 1'b1, brownoutMode)
		wr(OFF_WEN, 8'h10);
		wr(OFF_SLPCTL, 8'ha0);
		waitSig(S_LD, 1, 4, n);
		`CHK("timer load", 1'b1, n < 4)
		waitSig(S_WK, 0, 10, n);
		waitSig(S_RUN, 1, 5, n);
		`CHK("timer runs asleep", 1'b1, n < 5)
		u_rwc_far_model.drivePin(SRC_RX, 1'b1);
		waitSig(S_WK, 1, 400, n);
		`CHK("rx wake time", 1'b1, n >= 80 && n < 400)
		chkReg(OFF_WFLAG, 8'h10, 8'h10, "rx flag");
		wr(OFF_WEN, 8'h04);
		wr(OFF_SLPCTL, 8'ha0);
		waitSig(S_WK, 0, 10, n);
		u_rwc_far_model.drivePin(2, 1'b1);
		repeat (40) @(posedge core_clk);
		u_rwc_far_model.drivePin(2, 1'b0);
		waitSig(S_WK, 1, 300, n);
		`CHK("short pulse ignored", 300, n)
		@(posedge core_clk);
		wakeTimerExpired <= 1'b1;
		waitSig(S_WK, 1, 100, n);
		`CHK("timer wake", 1'b1, n < 100)
		@(posedge core_clk);
		wakeTimerExpired <= 1'b0;
		chkReg(OFF_WFLAG, 8'h30, 8'h20, "timer flag only");
		wr(OFF_WEN, 8'h08);
		u_rwc_far_model.drivePin(SRC_PB, 1'b1);
		repeat (100) @(posedge core_clk);
		chkReg(OFF_WFLAG, 8'h08, 8'h08, "pb flag awake");
		u_rwc_far_model.drivePin(SRC_PB, 1'b0);
		@(posedge core_clk);
		powerStatusField <= VSTAT_LOW;
		waitSig(S_RST, 0, 200, n);
		`CHK("low supply delay", 1'b1, n >= 3 * TICK && n < 200)
		repeat (4) @(posedge core_clk);
		#1;
		`CHK("held wake low", 1'b0, wakeSignal)
		@(posedge core_clk);
		powerStatusField <= 3'h2;
		waitSig(S_RST, 1, 200, n);
		`CHK("supply recovery", 1'b1, n < 200)
		chkReg(OFF_CAUSE, 8'h04, 8'h04, "lowbat flag");
		// firmware sleeps at once on low supply; the released but still-debounced button level then tries a wake
		@(posedge core_clk);
		powerStatusField <= VSTAT_LOW;
		wr(OFF_SLPCTL, 8'h80);
		repeat (40) @(posedge core_clk);
		#1;
		`CHK("held on wake attempt", 2'b10, {brownoutMode, wakeSignal})
		@(posedge core_clk);
		powerStatusField <= 3'h2;
		waitSig(S_RST, 1, 200, n);
		`CHK("recovery after sleep", 1'b1, n < 200)
		$display("test battery_wake finished");
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		end_of_test();
	end
endmodule : test_reset_and_wake_controller
